// *** verilog/lmc_map.svh ***
/*
 * Register offsets, field widths, reset values and bus constants of the line
 * interface mode and configuration mux. Assumes a 32-bit APB with byte addresses.
 */
// Notes on behaviour
// RL1 - Strap high: config from pins, status on pins.
// RL2 - Strap mode blocks every register access.
// RL3 - Strap low: config and status via registers.
// RL4 - Processor mode reuses pins as register bus.
// RL5 - Interrupt when flagged event is enabled.
// RL6 - Every strap pin has a matching register bit.
// RL7 - All register bits are active high.
// RL8 - Loss pin active low, status bit high.
// RL9 - Live inputs: pin OR register bit.
// RL10 - Float driver on low pin or bit.
// RL11 - Transmit, receive, global pins live always; the global pins here are read in strap mode only.
// RL12 - Strap-only pins honoured in strap mode.
// RL13 - Bus pins and interrupt only processor mode.
// RL14 - System supplies three accurate reference clocks.
// RL15 - Per-port pins and bits replicated four times.
// RL16 - Floating keeps transmitter running, driver off.
// RL17 - Both jitter requests: attenuator on transmit.
// RL18 - Board holds mode strap static.
// RL19 - Strap mode: bus ignored, data undriven; the code answers with PSLVERR_O and drives PRDATA_O to zero.
`ifndef LMC_MAP_SVH
`define LMC_MAP_SVH
`define LMC_ADDR_W 8
`define LMC_DATA_W 32
`define LMC_OFS_GLOBAL 8'h00
`define LMC_OFS_LIVE 8'h04
`define LMC_OFS_EVENT 8'h08
`define LMC_OFS_MASK 8'h0C
`define LMC_OFS_PORT0 8'h10
`define LMC_PORT_STRIDE 8'h04
`define LMC_PORT_CFG_W 10
`define LMC_GLB_W 4
`define LMC_RST_PORT_CFG 10'h000
`define LMC_RST_GLB 4'h0
`define LMC_RST_MASK 8'h00
`define LMC_RST_RDATA 32'h00000000
`endif

// *** verilog/lmc_pkg.sv ***
/*
 * Types shared by the mode and configuration mux modules.
 * Assumes the constants of lmc_map.svh for widths.
 */
package lmc_pkg;
    typedef enum logic {LMC_MODE_PROC, LMC_MODE_STRAP} lmc_mode_t;

    // Per-port configuration word, bit 0 at the bottom of the list.
    typedef struct packed {
        logic tx_float;
        logic sonet_rate_select;
        logic e3_rate_select;
        logic far_loop_select;
        logic near_loop_select;
        logic rx_jitter_atten_on;
        logic tx_jitter_atten_on;
        logic tx_cable_shaping;
        logic tx_source_sel_b;
        logic tx_source_sel_a;
    } lmc_cfg_t;

    typedef struct packed {
        logic tx_clock_invert;
        logic rx_clock_invert;
        logic tx_binary_iface;
        logic rx_binary_iface;
    } lmc_glb_t;
endpackage : lmc_pkg

// *** verilog/lmc_port_merge.sv ***
/*
 * Combinational merge of strap pins and register bits for one line port.
 * Assumes the mode input is already registered and static in operation.
 */
`timescale 1ns/1ps
module lmc_port_merge
    import lmc_pkg::*;
(
    input wire lmc_mode_t mode_i,
    input wire lmc_cfg_t pin_i,
    input wire logic tx_line_float_n_i,
    input wire lmc_cfg_t reg_i,
    output lmc_cfg_t eff_o,
    output logic drv_en_o
);
    lmc_cfg_t sel;

    always_comb
    begin
        sel = (mode_i == LMC_MODE_STRAP) ? pin_i : reg_i; // RL1 RL3 RL12 RL6
        eff_o = sel;
        // The float pin stays live in both modes; processor mode ORs in the register bit.
        eff_o.tx_float = !tx_line_float_n_i || (mode_i == LMC_MODE_PROC && reg_i.tx_float); // RL9 RL10 RL11
        // Transmit placement wins when both paths ask for the attenuator.
        eff_o.rx_jitter_atten_on = sel.rx_jitter_atten_on && !sel.tx_jitter_atten_on; // RL17
        drv_en_o = !eff_o.tx_float; // RL16
    end
endmodule : lmc_port_merge

// *** verilog/lmc_irq_ctrl.sv ***
/*
 * Sticky event flags, write-one-to-clear, with a mask and a level interrupt.
 * Assumes the loss and fault levels are synchronous to the core clock.
 */
`timescale 1ns/1ps
`include "lmc_map.svh"
module lmc_irq_ctrl
    import lmc_pkg::*;
#(
    parameter int PORTS = 4
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire lmc_mode_t mode_i,
    input wire logic [2*PORTS-1:0] level_i,
    input wire logic clr_we_i,
    input wire logic mask_we_i,
    input wire logic [2*PORTS-1:0] wdata_i,
    output logic [2*PORTS-1:0] status_o,
    output logic [2*PORTS-1:0] mask_o,
    output logic irq_o
);
    typedef struct packed {
        logic [2*PORTS-1:0] prev;
        logic [2*PORTS-1:0] status;
        logic [2*PORTS-1:0] mask;
        logic irq;
    } lmc_irq_state_t;

    lmc_irq_state_t s;
    lmc_irq_state_t next_s;
    logic [2*PORTS-1:0] rise;

    always_comb
    begin
        rise = level_i & ~s.prev;
        next_s = s;
        next_s.prev = level_i;
        // A new event in the clearing cycle keeps its flag set.
        next_s.status = (s.status & ~(clr_we_i ? wdata_i : '0)) | rise; // RL7
        if (mask_we_i)
        begin
            next_s.mask = wdata_i;
        end
        next_s.irq = (mode_i == LMC_MODE_PROC) && |(next_s.status & next_s.mask); // RL5 RL13
        if (!rst_b_i)
        begin
            next_s = '0;
            next_s.mask = (2*PORTS)'(`LMC_RST_MASK);
        end
    end

    always_ff @(posedge clk_i)
    begin
        s <= next_s;
    end

    assign status_o = s.status;
    assign mask_o = s.mask;
    assign irq_o = s.irq;

    property p_event_sticks;
        @(posedge clk_i) disable iff (!rst_b_i)
        level_i[0] && !s.prev[0]
        |=> status_o[0] ##1 (status_o[0] || $past(clr_we_i && wdata_i[0]));
    endproperty
    a_event_sticks: assert property (p_event_sticks) // RL7
        else $error("event flag not set or lost");

    property p_irq_level;
        @(posedge clk_i) disable iff (!rst_b_i)
        ##1 (mode_i == LMC_MODE_PROC && $past(mode_i) == LMC_MODE_PROC)
        |-> irq_o == |(status_o & mask_o);
    endproperty
    a_irq_level: assert property (p_irq_level) // RL5
        else $error("interrupt does not follow enabled flags");
endmodule : lmc_irq_ctrl

// *** verilog/lmc_mode_mux.sv ***
/*
 * Mode selection and configuration source mux for a multi-port line interface.
 * Holds the APB register file, merges pins and register bits per port, and
 * drives the effective settings and status pins. Assumes all inputs are
 * synchronous to CORE_CLK_I and that the mode strap is wired static.
 */
`timescale 1ns/1ps
`include "lmc_map.svh"
module lmc_mode_mux
    import lmc_pkg::*;
#(
    parameter int PORTS = 4
)
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic STRAP_MODE_SELECT_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [`LMC_ADDR_W-1:0] PADDR_I,
    input wire logic [`LMC_DATA_W-1:0] PWDATA_I,
    output logic [`LMC_DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [PORTS-1:0] TX_SOURCE_SEL_A_I,
    input wire logic [PORTS-1:0] TX_SOURCE_SEL_B_I,
    input wire logic [PORTS-1:0] TX_CABLE_SHAPING_I,
    input wire logic [PORTS-1:0] TX_JITTER_ATTEN_ON_I,
    input wire logic [PORTS-1:0] RX_JITTER_ATTEN_ON_I,
    input wire logic [PORTS-1:0] NEAR_LOOP_SELECT_I,
    input wire logic [PORTS-1:0] FAR_LOOP_SELECT_I,
    input wire logic [PORTS-1:0] E3_RATE_SELECT_I,
    input wire logic [PORTS-1:0] SONET_RATE_SELECT_I,
    input wire logic [PORTS-1:0] TX_LINE_FLOAT_N_I,
    input wire logic RX_BINARY_IFACE_I,
    input wire logic TX_BINARY_IFACE_I,
    input wire logic RX_CLOCK_INVERT_I,
    input wire logic TX_CLOCK_INVERT_I,
    input wire logic [PORTS-1:0] RX_SIGNAL_LOSS_I,
    input wire logic [PORTS-1:0] TX_DRIVER_FAULT_I,
    output logic [PORTS-1:0] TX_SOURCE_SEL_A_O,
    output logic [PORTS-1:0] TX_SOURCE_SEL_B_O,
    output logic [PORTS-1:0] TX_CABLE_SHAPING_O,
    output logic [PORTS-1:0] TX_JITTER_ATTEN_ON_O,
    output logic [PORTS-1:0] RX_JITTER_ATTEN_ON_O,
    output logic [PORTS-1:0] NEAR_LOOP_SELECT_O,
    output logic [PORTS-1:0] FAR_LOOP_SELECT_O,
    output logic [PORTS-1:0] E3_RATE_SELECT_O,
    output logic [PORTS-1:0] SONET_RATE_SELECT_O,
    output logic [PORTS-1:0] TX_DRIVER_EN_O,
    output logic RX_BINARY_IFACE_O,
    output logic TX_BINARY_IFACE_O,
    output logic RX_CLOCK_INVERT_O,
    output logic TX_CLOCK_INVERT_O,
    output logic [PORTS-1:0] RX_SIGNAL_LOSS_N_O,
    output logic [PORTS-1:0] TX_MONITOR_N_O,
    output logic [PORTS-1:0] TX_MONITOR_OE_O,
    output logic IRQ_O
);
    typedef struct packed {
        lmc_mode_t mode;
        lmc_glb_t glb;
        lmc_glb_t glb_eff;
        lmc_cfg_t [PORTS-1:0] cfg;
        lmc_cfg_t [PORTS-1:0] eff;
        logic [PORTS-1:0] drv_en;
        logic [PORTS-1:0] loss_n;
        logic [PORTS-1:0] fault;
        logic [`LMC_DATA_W-1:0] rdata;
        logic err;
    } lmc_top_state_t;

    lmc_top_state_t s;
    lmc_top_state_t next_s;
    lmc_cfg_t [PORTS-1:0] eff_c;
    logic [PORTS-1:0] drv_en_c;
    logic [2*PORTS-1:0] status;
    logic [2*PORTS-1:0] mask;
    logic setup;
    logic access;
    logic wr_ok;
    logic clr_we;
    logic mask_we;
    logic irq;

    assign setup = PSEL_I && !PENABLE_I;
    assign access = PSEL_I && PENABLE_I;
    // Writes land only in processor mode; strap mode keeps the register file sealed.
    assign wr_ok = access && PWRITE_I && s.mode == LMC_MODE_PROC; // RL2 RL19
    assign clr_we = wr_ok && PADDR_I == `LMC_OFS_EVENT;
    assign mask_we = wr_ok && PADDR_I == `LMC_OFS_MASK;

    genvar gi;
    generate
        for (gi = 0; gi < PORTS; gi++)
        begin : g_port
            lmc_cfg_t pin;
            always_comb
            begin
                pin = '0;
                pin.tx_source_sel_a = TX_SOURCE_SEL_A_I[gi];
                pin.tx_source_sel_b = TX_SOURCE_SEL_B_I[gi];
                pin.tx_cable_shaping = TX_CABLE_SHAPING_I[gi];
                pin.tx_jitter_atten_on = TX_JITTER_ATTEN_ON_I[gi];
                pin.rx_jitter_atten_on = RX_JITTER_ATTEN_ON_I[gi];
                pin.near_loop_select = NEAR_LOOP_SELECT_I[gi];
                pin.far_loop_select = FAR_LOOP_SELECT_I[gi];
                pin.e3_rate_select = E3_RATE_SELECT_I[gi];
                pin.sonet_rate_select = SONET_RATE_SELECT_I[gi];
            end

            lmc_port_merge u_merge (
                .mode_i(s.mode),
                .pin_i(pin),
                .tx_line_float_n_i(TX_LINE_FLOAT_N_I[gi]),
                .reg_i(s.cfg[gi]),
                .eff_o(eff_c[gi]),
                .drv_en_o(drv_en_c[gi])
            ); // RL15

            assign TX_SOURCE_SEL_A_O[gi] = s.eff[gi].tx_source_sel_a;
            assign TX_SOURCE_SEL_B_O[gi] = s.eff[gi].tx_source_sel_b;
            assign TX_CABLE_SHAPING_O[gi] = s.eff[gi].tx_cable_shaping;
            assign TX_JITTER_ATTEN_ON_O[gi] = s.eff[gi].tx_jitter_atten_on;
            assign RX_JITTER_ATTEN_ON_O[gi] = s.eff[gi].rx_jitter_atten_on;
            assign NEAR_LOOP_SELECT_O[gi] = s.eff[gi].near_loop_select;
            assign FAR_LOOP_SELECT_O[gi] = s.eff[gi].far_loop_select;
            assign E3_RATE_SELECT_O[gi] = s.eff[gi].e3_rate_select;
            assign SONET_RATE_SELECT_O[gi] = s.eff[gi].sonet_rate_select;
        end
    endgenerate

    lmc_irq_ctrl #(
        .PORTS(PORTS)
    ) u_irq (
        .clk_i(CORE_CLK_I),
        .rst_b_i(RST_B_I),
        .mode_i(s.mode),
        .level_i({TX_DRIVER_FAULT_I, RX_SIGNAL_LOSS_I}),
        .clr_we_i(clr_we),
        .mask_we_i(mask_we),
        .wdata_i(PWDATA_I[2*PORTS-1:0]),
        .status_o(status),
        .mask_o(mask),
        .irq_o(irq)
    );

    always_comb
    begin
        next_s = s;
        // The strap is treated as static, so it is simply sampled every cycle.
        next_s.mode = STRAP_MODE_SELECT_I ? LMC_MODE_STRAP : LMC_MODE_PROC; // RL1 RL3 RL18
        next_s.eff = eff_c;
        next_s.drv_en = drv_en_c; // RL16
        next_s.loss_n = ~RX_SIGNAL_LOSS_I; // RL8 RL11
        next_s.fault = TX_DRIVER_FAULT_I; // RL11
        if (s.mode == LMC_MODE_STRAP)
        begin
            next_s.glb_eff.rx_binary_iface = RX_BINARY_IFACE_I; // RL12
            next_s.glb_eff.tx_binary_iface = TX_BINARY_IFACE_I;
            next_s.glb_eff.rx_clock_invert = RX_CLOCK_INVERT_I;
            next_s.glb_eff.tx_clock_invert = TX_CLOCK_INVERT_I;
        end
        else
        begin
            next_s.glb_eff = s.glb; // RL3 RL6
        end

        // Read data and the error answer are prepared in the setup cycle.
        if (setup)
        begin
            next_s.rdata = `LMC_RST_RDATA;
            next_s.err = 1'b0;
            if (s.mode == LMC_MODE_STRAP)
            begin
                next_s.err = 1'b1; // RL2 RL19
            end
            else if (PADDR_I == `LMC_OFS_GLOBAL)
            begin
                next_s.rdata[`LMC_GLB_W-1:0] = s.glb;
            end
            else if (PADDR_I == `LMC_OFS_LIVE)
            begin
                next_s.rdata[2*PORTS-1:0] = {TX_DRIVER_FAULT_I, RX_SIGNAL_LOSS_I}; // RL7 RL8
            end
            else if (PADDR_I == `LMC_OFS_EVENT)
            begin
                next_s.rdata[2*PORTS-1:0] = status;
            end
            else if (PADDR_I == `LMC_OFS_MASK)
            begin
                next_s.rdata[2*PORTS-1:0] = mask;
            end
            else
            begin
                next_s.err = 1'b1;
                for (int i = 0; i < PORTS; i++)
                begin
                    if (PADDR_I == `LMC_ADDR_W'(`LMC_OFS_PORT0 + i * `LMC_PORT_STRIDE))
                    begin
                        next_s.rdata[`LMC_PORT_CFG_W-1:0] = s.cfg[i];
                        next_s.err = 1'b0;
                    end
                end
            end
        end

        if (wr_ok)
        begin
            if (PADDR_I == `LMC_OFS_GLOBAL)
            begin
                next_s.glb = PWDATA_I[`LMC_GLB_W-1:0]; // RL4 RL6
            end
            else
            begin
                for (int i = 0; i < PORTS; i++)
                begin
                    if (PADDR_I == `LMC_ADDR_W'(`LMC_OFS_PORT0 + i * `LMC_PORT_STRIDE))
                    begin
                        next_s.cfg[i] = PWDATA_I[`LMC_PORT_CFG_W-1:0]; // RL6 RL15
                    end
                end
            end
        end

        if (!RST_B_I)
        begin
            next_s = '0;
            next_s.mode = LMC_MODE_STRAP;
            next_s.glb = `LMC_RST_GLB;
            next_s.cfg = {PORTS{`LMC_RST_PORT_CFG}};
            next_s.loss_n = '1;
            next_s.rdata = `LMC_RST_RDATA;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        s <= next_s;
    end

    assign PRDATA_O = s.rdata;
    assign PREADY_O = access;
    assign PSLVERR_O = access && s.err;
    assign TX_DRIVER_EN_O = s.drv_en;
    assign RX_BINARY_IFACE_O = s.glb_eff.rx_binary_iface;
    assign TX_BINARY_IFACE_O = s.glb_eff.tx_binary_iface;
    assign RX_CLOCK_INVERT_O = s.glb_eff.rx_clock_invert;
    assign TX_CLOCK_INVERT_O = s.glb_eff.tx_clock_invert;
    assign RX_SIGNAL_LOSS_N_O = s.loss_n;
    // Open-drain monitor pin: only ever pulls low, the board pulls it up.
    assign TX_MONITOR_N_O = '0;
    assign TX_MONITOR_OE_O = s.fault;
    assign IRQ_O = irq;

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    property p_strap_no_write;
        s.mode == LMC_MODE_STRAP && access && PWRITE_I |=> $stable(s.cfg) && $stable(s.glb);
    endproperty
    a_strap_no_write: assert property (p_strap_no_write) // RL2
        else $error("register changed by a write in strap mode");

    property p_strap_err;
        s.mode == LMC_MODE_STRAP && $past(s.mode) == LMC_MODE_STRAP && access
        |-> PSLVERR_O && PRDATA_O == `LMC_RST_RDATA;
    endproperty
    a_strap_err: assert property (p_strap_err) // RL19
        else $error("bus access not refused in strap mode");

    property p_strap_pin_cfg;
        s.mode == LMC_MODE_STRAP ##0 STRAP_MODE_SELECT_I
        |=> NEAR_LOOP_SELECT_O[0] == $past(NEAR_LOOP_SELECT_I[0]);
    endproperty
    a_strap_pin_cfg: assert property (p_strap_pin_cfg) // RL1
        else $error("strap mode output does not follow its pin");

    property p_proc_reg_cfg;
        s.mode == LMC_MODE_PROC && !STRAP_MODE_SELECT_I
        |=> E3_RATE_SELECT_O[0] == $past(s.cfg[0].e3_rate_select);
    endproperty
    a_proc_reg_cfg: assert property (p_proc_reg_cfg) // RL3
        else $error("processor mode output does not follow its register");

    property p_float_pin;
        !TX_LINE_FLOAT_N_I[0] |=> !TX_DRIVER_EN_O[0];
    endproperty
    a_float_pin: assert property (p_float_pin) // RL10
        else $error("driver enabled while float pin is low");

    property p_float_or;
        s.mode == LMC_MODE_PROC && TX_LINE_FLOAT_N_I[0]
        |=> TX_DRIVER_EN_O[0] == !$past(s.cfg[0].tx_float);
    endproperty
    a_float_or: assert property (p_float_or) // RL9
        else $error("float register bit not applied");

    property p_loss_pin;
        RX_SIGNAL_LOSS_I[0] |=> !RX_SIGNAL_LOSS_N_O[0] ##1 (RX_SIGNAL_LOSS_N_O[0] == !$past(RX_SIGNAL_LOSS_I[0]));
    endproperty
    a_loss_pin: assert property (p_loss_pin) // RL8
        else $error("loss pin polarity wrong");

    property p_ja_tx_wins;
        !(TX_JITTER_ATTEN_ON_O[0] && RX_JITTER_ATTEN_ON_O[0]);
    endproperty
    a_ja_tx_wins: assert property (p_ja_tx_wins) // RL17
        else $error("attenuator placed in both paths");

    property p_irq_strap;
        s.mode == LMC_MODE_STRAP ##1 s.mode == LMC_MODE_STRAP |-> !IRQ_O;
    endproperty
    a_irq_strap: assert property (p_irq_strap) // RL13
        else $error("interrupt raised in strap mode");

    property p_glb_proc;
        s.mode == LMC_MODE_PROC && !STRAP_MODE_SELECT_I
        |=> RX_CLOCK_INVERT_O == $past(s.glb.rx_clock_invert);
    endproperty
    a_glb_proc: assert property (p_glb_proc) // RL6
        else $error("global output does not follow its register");

    property p_strap_glb;
        s.mode == LMC_MODE_STRAP && STRAP_MODE_SELECT_I
        |=> TX_BINARY_IFACE_O == $past(TX_BINARY_IFACE_I);
    endproperty
    a_strap_glb: assert property (p_strap_glb) // RL12
        else $error("global output does not follow its strap pin");

    property p_monitor;
        TX_DRIVER_FAULT_I[0] |=> TX_MONITOR_OE_O[0] && !TX_MONITOR_N_O[0];
    endproperty
    a_monitor: assert property (p_monitor) // RL11
        else $error("driver monitor not pulled low on a fault");

    c_proc_write: cover property (s.mode == LMC_MODE_PROC && access && PWRITE_I && !PSLVERR_O);
    c_strap_refuse: cover property (PSLVERR_O);
    c_irq: cover property (IRQ_O);
    c_float: cover property (!TX_DRIVER_EN_O[0]);
    c_strap_loss: cover property (s.mode == LMC_MODE_STRAP && !RX_SIGNAL_LOSS_N_O[0]);
endmodule : lmc_mode_mux

// *** verification/lmc_line_model.sv ***
/*
 * Line side of the mux: receiver loss and driver fault levels, and the
 * pulled-up driver monitor wire. Assumes requests arrive from the bench.
 */
`timescale 1ns/1ps
module lmc_line_model #(
    parameter int PORTS = 4
)
(
    input wire logic clk_i,
    input wire logic [PORTS-1:0] loss_req_i,
    input wire logic [PORTS-1:0] fault_req_i,
    input wire logic [PORTS-1:0] mon_n_i,
    input wire logic [PORTS-1:0] mon_oe_i,
    output logic [PORTS-1:0] loss_o,
    output logic [PORTS-1:0] fault_o,
    output logic [PORTS-1:0] mon_wire_o
);
    // Levels change just after an edge, as a synchronous receiver would.
    always_ff @(posedge clk_i)
    begin
        loss_o <= loss_req_i;
        fault_o <= fault_req_i;
    end

    // The external pull-up sets the wire high whenever nobody drives it.
    always_comb
    begin
        for (int i = 0; i < PORTS; i++)
        begin
            mon_wire_o[i] = mon_oe_i[i] ? mon_n_i[i] : 1'b1;
        end
    end

    // Board reference clocks at the rated line rates; the mux itself never reads them.
    logic ds3_ref_clock = 1'b0;
    logic e3_ref_clock = 1'b0;
    logic sonet_ref_clock = 1'b0;
    always #(500.0 / 44.736) ds3_ref_clock = ~ds3_ref_clock;
    always #(500.0 / 34.368) e3_ref_clock = ~e3_ref_clock;
    always #(500.0 / 51.840) sonet_ref_clock = ~sonet_ref_clock;
endmodule : lmc_line_model

// *** verification/liu_mode_config_mux_tb.sv ***
/*
 * Self-checking bench of the mode and configuration mux.
 * Assumes lmc_map.svh on the include path and the line model beside it.
 */
`timescale 1ns/1ps
`include "lmc_map.svh"
module liu_mode_config_mux_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    logic [3:0] pin [0:8];
    logic [3:0] glb_pin = 4'hF;
    logic [3:0] float_n = 4'hF;
    logic [3:0] loss_req = 4'h0;
    logic [3:0] fault_req = 4'h0;
    wire [3:0] po [0:8];
    wire [3:0] glb_o;
    wire [3:0] drv_en, loss_n, mon_n, mon_oe, loss, fault, mon_wire;
    wire irq;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;

    lmc_mode_mux #(.PORTS(4)) lmc_mode_mux_i (
        .CORE_CLK_I(clk), .RST_B_I(rst_b), .STRAP_MODE_SELECT_I(strap),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .TX_SOURCE_SEL_A_I(pin[0]), .TX_SOURCE_SEL_B_I(pin[1]),
        .TX_CABLE_SHAPING_I(pin[2]), .TX_JITTER_ATTEN_ON_I(pin[3]),
        .RX_JITTER_ATTEN_ON_I(pin[4]), .NEAR_LOOP_SELECT_I(pin[5]),
        .FAR_LOOP_SELECT_I(pin[6]), .E3_RATE_SELECT_I(pin[7]),
        .SONET_RATE_SELECT_I(pin[8]), .TX_LINE_FLOAT_N_I(float_n),
        .RX_BINARY_IFACE_I(glb_pin[0]), .TX_BINARY_IFACE_I(glb_pin[1]),
        .RX_CLOCK_INVERT_I(glb_pin[2]), .TX_CLOCK_INVERT_I(glb_pin[3]),
        .RX_SIGNAL_LOSS_I(loss), .TX_DRIVER_FAULT_I(fault),
        .TX_SOURCE_SEL_A_O(po[0]), .TX_SOURCE_SEL_B_O(po[1]),
        .TX_CABLE_SHAPING_O(po[2]), .TX_JITTER_ATTEN_ON_O(po[3]),
        .RX_JITTER_ATTEN_ON_O(po[4]), .NEAR_LOOP_SELECT_O(po[5]),
        .FAR_LOOP_SELECT_O(po[6]), .E3_RATE_SELECT_O(po[7]),
        .SONET_RATE_SELECT_O(po[8]), .TX_DRIVER_EN_O(drv_en),
        .RX_BINARY_IFACE_O(glb_o[0]), .TX_BINARY_IFACE_O(glb_o[1]),
        .RX_CLOCK_INVERT_O(glb_o[2]), .TX_CLOCK_INVERT_O(glb_o[3]),
        .RX_SIGNAL_LOSS_N_O(loss_n), .TX_MONITOR_N_O(mon_n),
        .TX_MONITOR_OE_O(mon_oe), .IRQ_O(irq)
    );

    lmc_line_model #(.PORTS(4)) lmc_line_model_i (
        .clk_i(clk), .loss_req_i(loss_req), .fault_req_i(fault_req), .mon_n_i(mon_n),
        .mon_oe_i(mon_oe), .loss_o(loss), .fault_o(fault), .mon_wire_o(mon_wire)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // The slave raises ready in its first access cycle; the loop gives up after 50 cycles without ready.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50)
        begin
            chk(32'h0, 32'h1, "no ready");
            report_and_stop();
        end
    endtask : apb

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk({31'h0, e}, {31'h0, xe}, "error flag");
    endtask : rchk

    task automatic do_reset(input logic s);
        @(posedge clk);
        strap <= s;
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        settle(2);
    endtask : do_reset

    task automatic t_proc_regs;
        chk(glb_o, 4'h0, "strap pins ignored");
        rchk(`LMC_OFS_GLOBAL, 32'h0, 1'b0);
        rchk(`LMC_OFS_MASK, 32'h0, 1'b0);
        rchk(`LMC_OFS_PORT0, 32'h0, 1'b0);
        rchk(8'hFC, 32'h0, 1'b1);
        wreg(`LMC_OFS_GLOBAL, 32'h0000000F);
        settle(2);
        chk(glb_o, 4'hF, "global bits");
        rchk(`LMC_OFS_GLOBAL, 32'h0000000F, 1'b0);
        wreg(`LMC_OFS_GLOBAL, 32'h0);
        $display("test proc_regs done");
    endtask : t_proc_regs

    task automatic t_proc_ports;
        logic [7:0] a;
        for (int i = 0; i < 4; i++)
        begin
            a = `LMC_OFS_PORT0 + 8'(4 * i);
            for (int k = 0; k < 9; k++)
            begin
                wreg(a, 32'h1 << k);
                settle(2);
                for (int j = 0; j < 9; j++)
                    chk(po[j], (j == k) ? 4'h1 << i : 4'h0, "port field");
            end
            wreg(a, 32'h00000018);
            settle(2);
            chk(po[3], 4'h1 << i, "tx attenuator");
            chk(po[4], 4'h0, "rx attenuator");
            wreg(a, 32'h00000200);
            settle(2);
            chk(drv_en, 4'hF ^ (4'h1 << i), "float bit");
            wreg(a, 32'h0);
        end
        float_n <= 4'hB;
        settle(2);
        chk(drv_en, 4'hB, "float pin live");
        @(posedge clk);
        float_n <= 4'hF;
        settle(2);
        chk(drv_en, 4'hF, "driver on");
        $display("test proc_ports done");
    endtask : t_proc_ports

    task automatic t_irq;
        wreg(`LMC_OFS_MASK, 32'h01);
        loss_req <= 4'h1;
        settle(4);
        chk(irq, 1'b1, "irq on loss");
        chk(loss_n, 4'hE, "loss pin low");
        rchk(`LMC_OFS_EVENT, 32'h01, 1'b0);
        rchk(`LMC_OFS_LIVE, 32'h01, 1'b0);
        fault_req <= 4'h2;
        settle(4);
        chk(mon_wire, 4'hD, "monitor wire");
        rchk(`LMC_OFS_EVENT, 32'h21, 1'b0);
        wreg(`LMC_OFS_EVENT, 32'h01);
        settle(1);
        chk(irq, 1'b0, "masked fault");
        rchk(`LMC_OFS_EVENT, 32'h20, 1'b0);
        wreg(`LMC_OFS_MASK, 32'h20);
        settle(1);
        chk(irq, 1'b1, "unmasked fault");
        @(posedge clk);
        loss_req <= 4'h0;
        fault_req <= 4'h0;
        wreg(`LMC_OFS_EVENT, 32'hFF);
        settle(1);
        chk(irq, 1'b0, "cleared");
        rchk(`LMC_OFS_EVENT, 32'h0, 1'b0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_strap;
        for (int k = 0; k < 9; k++)
            pin[k] <= 4'h0;
        glb_pin <= 4'h0;
        do_reset(1'b1);
        wreg(`LMC_OFS_GLOBAL, 32'h0000000F);
        rchk(`LMC_OFS_GLOBAL, 32'h0, 1'b1);
        chk(glb_o, 4'h0, "no write");
        for (int k = 0; k < 9; k++)
        begin
            pin[k] <= 4'h5;
            settle(2);
            for (int j = 0; j < 9; j++)
                chk(po[j], (j == k) ? 4'h5 : 4'h0, "pin field");
            @(posedge clk);
            pin[k] <= 4'h0;
        end
        pin[3] <= 4'hF;
        pin[4] <= 4'hF;
        glb_pin <= 4'hA;
        float_n <= 4'h6;
        loss_req <= 4'hF;
        settle(4);
        chk(po[4], 4'h0, "rx attenuator");
        chk(glb_o, 4'hA, "global pins");
        chk(drv_en, 4'h6, "float pin");
        chk(loss_n, 4'h0, "loss pins");
        chk(irq, 1'b0, "irq off");
        $display("test strap done");
    endtask : t_strap

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            report_and_stop();
        end
    end

    initial
    begin
        for (int k = 0; k < 9; k++)
            pin[k] = 4'hF;
        do_reset(1'b0);
        t_proc_regs();
        t_proc_ports();
        t_irq();
        t_strap();
        report_and_stop();
    end
endmodule : liu_mode_config_mux_tb
